// ---- rtl/irq_ctrl_pkg.sv ----
// constants, register map and state codes of the interrupt and sleep controller
package irq_ctrl_pkg;

    // register addresses on the internal register port
    localparam logic [7:0] PRIO_ADDR   = 8'hF9;
    localparam logic [7:0] PEND_ADDR   = 8'hFA;
    localparam logic [7:0] MASK_ADDR   = 8'hFB;

    // values after reset
    localparam logic [7:0] PRIO_RESET  = 8'h00;
    localparam logic [5:0] PEND_RESET  = 6'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] RDATA_IDLE  = 8'h00;

    // field positions
    localparam int NUM_REQ       = 6;
    localparam int NUM_SRC       = 8;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PRIO_DIR_BIT  = 3;
    localparam int PRIO_TOP_LSB  = 0;

    // entry sequence, counted in input clock periods after the sample point
    localparam logic [5:0] STACK_CYCLES    = 6'h30;
    localparam logic [5:0] VECTOR_CYCLES   = 6'h09;
    localparam logic [5:0] ISR_FETCH_CYCLE = 6'(STACK_CYCLES + VECTOR_CYCLES + 6'h01);
    localparam logic [5:0] PUSH_PCL_CYCLE  = 6'h10;
    localparam logic [5:0] PUSH_PCH_CYCLE  = 6'h20;
    localparam logic [5:0] PUSH_FLG_CYCLE  = STACK_CYCLES;
    localparam logic [5:0] VEC_HI_CYCLE    = 6'h32;
    localparam logic [5:0] VEC_LO_CYCLE    = 6'h36;
    localparam logic [5:0] CYC_RESET       = 6'h00;

    // push selector codes
    localparam logic [1:0] PUSH_PCL = 2'h0;
    localparam logic [1:0] PUSH_PCH = 2'h1;
    localparam logic [1:0] PUSH_FLG = 2'h2;

    // program memory addresses
    localparam logic [15:0] VECTOR_BASE  = 16'h0000;
    localparam logic [15:0] RESTART_ADDR = 16'h000C;
    localparam logic [15:0] ADDR_RESET   = 16'h0000;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_SEQ  = 2'b01,
        ST_HALT = 2'b10,
        ST_STOP = 2'b11
    } ctrl_state_t;

endpackage

// ---- rtl/priority_pick.sv ----
// programmable priority encoder over the six enabled requests
`timescale 1ns/10ps
module priority_pick (
    input  wire logic [5:0] req_in,
    input  wire logic [2:0] top_in,
    input  wire logic       dir_in,
    output logic            hit_out,
    output logic [2:0]      idx_out
);
    // walk from lowest rank upward so the best rank is written last
    always_comb begin
        int t;
        int p;
        t = (top_in > 3'h5) ? 0 : int'(top_in);
        p = 0;
        hit_out = 1'b0;
        idx_out = 3'h0;
        for (int k = 5; k >= 0; k--) begin
            p = dir_in ? ((t + 6 - k) % 6) : ((t + k) % 6);
            if (req_in[p]) begin
                hit_out = 1'b1;
                idx_out = 3'(p);
            end
        end
    end
endmodule // priority_pick

// ---- rtl/vectored_interrupt_and_sleep_control.sv ----
// interrupt controller with vectored entry sequence and halt/stop sleep control
//
// Overview of operation
// - eight sources merge into six requests: four port 3 lines, serial, two timers
// - mask register enables each request alone plus one global enable for all
// - software-written priority register steers the encoder choosing among pending requests
// - grant clears global enable, pushes PC and flags, then branches via vector
// - each vector is two bytes, high then low, forming the 16-bit routine address
// - pending register reads back at any time, masked or not, for polling
// - writing a one into a pending bit raises that interrupt like hardware
// - requests are sampled at the end of each instruction, and on every cycle in halt
// - forty-eight cycles after sampling prioritize and push both PC bytes and flags
// - the nine following cycles fetch the two vector bytes
// - first routine byte fetch starts fifty-eight cycles after the internal sample
// - halt stops the CPU clock while oscillator, timers and port requests run
// - halt ends only when an enabled interrupt is serviced
// - stop halts clock and oscillator until reset, restart at address 000C
// - priority at F9 write-only, pending at FA and mask at FB read/write
`timescale 1ns/10ps
module vectored_interrupt_and_sleep_control (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic        instr_end_in,
    input  wire logic        halt_cmd_in,
    input  wire logic        stop_cmd_in,
    input  wire logic [3:0]  port3_request_lines_in,
    input  wire logic        ser_tx_req_in,
    input  wire logic        ser_rx_req_in,
    input  wire logic        tmr0_req_in,
    input  wire logic        tmr1_req_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic [7:0]  vec_data_in,
    output logic [7:0]       reg_rdata_out,
    output logic             int_grant_out,
    output logic [2:0]       grant_id_out,
    output logic             cpu_hold_out,
    output logic             push_strobe_out,
    output logic [1:0]       push_sel_out,
    output logic             vec_rd_out,
    output logic [15:0]      vec_addr_out,
    output logic             isr_fetch_out,
    output logic [15:0]      isr_addr_out,
    output logic             cpu_clk_en_out,
    output logic             osc_en_out,
    output logic             timer_run_out,
    output logic [15:0]      restart_addr_out
);

    // port pins cross into the clock domain through two flops
    logic [3:0] p3_meta;
    logic [3:0] p3_sync;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            p3_meta <= 4'h0;
            p3_sync <= 4'h0;
        end else if (ce_in) begin
            p3_meta <= port3_request_lines_in;
            p3_sync <= p3_meta;
        end
    end

    // merge of eight sources onto six request lines
    logic [5:0] raw_req;
    logic [5:0] raw_prev;
    logic [5:0] hw_set;
    assign raw_req[0] = p3_sync[2];
    assign raw_req[1] = p3_sync[3];
    assign raw_req[2] = p3_sync[1];
    assign raw_req[3] = p3_sync[0] | ser_rx_req_in;
    assign raw_req[4] = ser_tx_req_in | tmr0_req_in;
    assign raw_req[5] = tmr1_req_in;

    // register state and sequencer state
    logic [7:0]                     prio;
    logic [5:0]                     pend;
    logic [7:0]                     mask;
    irq_ctrl_pkg::ctrl_state_t      st;
    logic [5:0]                     cyc;
    logic [2:0]                     cur_id;
    logic [7:0]                     vec_hi;
    logic [7:0]                     vec_lo;

    // rising edge of a merged line; frozen in stop since the oscillator is off
    assign hw_set = (st == irq_ctrl_pkg::ST_STOP) ? 6'h00 : (raw_req & ~raw_prev);

    // enabled requests and the encoder choice
    logic [5:0] serviceable;
    logic       pick_hit;
    logic [2:0] pick_idx;
    logic       sample_pt;
    logic       grant_now;
    assign serviceable = pend & mask[5:0] & {6{mask[irq_ctrl_pkg::GLOBAL_EN_BIT]}};

    priority_pick u_pick (
        .req_in  (serviceable),
        .top_in  (prio[irq_ctrl_pkg::PRIO_TOP_LSB +: 3]),
        .dir_in  (prio[irq_ctrl_pkg::PRIO_DIR_BIT]),
        .hit_out (pick_hit),
        .idx_out (pick_idx)
    );

    // sample at instruction end in run, and on every cycle in halt since a halted CPU has no instructions to finish
    assign sample_pt = ((st == irq_ctrl_pkg::ST_RUN) && instr_end_in) || (st == irq_ctrl_pkg::ST_HALT);
    assign grant_now = sample_pt && pick_hit;

    // register decode
    logic wr_prio;
    logic wr_pend;
    logic wr_mask;
    assign wr_prio = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::PRIO_ADDR);
    assign wr_pend = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::PEND_ADDR);
    assign wr_mask = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::MASK_ADDR);

    // register next values; a hardware set always beats a clear in the same cycle
    logic [7:0] next_prio;
    logic [5:0] next_pend;
    logic [7:0] next_mask;
    logic [7:0] next_rdata;
    always_comb begin
        next_prio  = prio;
        next_pend  = pend;
        next_mask  = mask;
        next_rdata = reg_rdata_out;
        if (st != irq_ctrl_pkg::ST_STOP) begin
            if (wr_prio) begin
                next_prio = reg_wdata_in;
            end
            if (wr_pend) begin
                next_pend = reg_wdata_in[5:0];
            end
            if (grant_now) begin
                next_pend[pick_idx] = 1'b0;
            end
            next_pend = next_pend | hw_set;
            if (wr_mask) begin
                next_mask = reg_wdata_in;
            end
            if (grant_now) begin
                next_mask[irq_ctrl_pkg::GLOBAL_EN_BIT] = 1'b0;
            end
        end
        // write-only and unmapped addresses read as zero
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                irq_ctrl_pkg::PEND_ADDR: next_rdata = {2'b00, pend};
                irq_ctrl_pkg::MASK_ADDR: next_rdata = mask;
                default:                 next_rdata = irq_ctrl_pkg::RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prio          <= irq_ctrl_pkg::PRIO_RESET;
            pend          <= irq_ctrl_pkg::PEND_RESET;
            mask          <= irq_ctrl_pkg::MASK_RESET;
            reg_rdata_out <= irq_ctrl_pkg::RDATA_IDLE;
            raw_prev      <= 6'h00;
        end else if (ce_in) begin
            prio          <= next_prio;
            pend          <= next_pend;
            mask          <= next_mask;
            reg_rdata_out <= next_rdata;
            raw_prev      <= raw_req;
        end
    end

    // sequencer next values; outputs are registered from the next cycle count
    irq_ctrl_pkg::ctrl_state_t next_st;
    logic [5:0]  next_cyc;
    logic [2:0]  next_id;
    logic [7:0]  next_vec_hi;
    logic [7:0]  next_vec_lo;
    logic        in_seq;
    logic        next_push;
    logic [1:0]  next_push_sel;
    logic        next_vec_rd;
    logic [15:0] next_vec_addr;
    logic        next_isr;
    logic [15:0] vec_slot;
    always_comb begin
        next_st       = st;
        next_cyc      = cyc;
        next_id       = cur_id;
        next_vec_hi   = vec_hi;
        next_vec_lo   = vec_lo;
        next_push     = 1'b0;
        next_push_sel = push_sel_out;
        next_vec_rd   = 1'b0;
        next_vec_addr = vec_addr_out;
        next_isr      = 1'b0;
        vec_slot      = irq_ctrl_pkg::VECTOR_BASE + {12'h000, cur_id, 1'b0};
        unique case (st)
            irq_ctrl_pkg::ST_RUN: begin
                if (grant_now) begin
                    next_st  = irq_ctrl_pkg::ST_SEQ;
                    next_cyc = 6'h01;
                    next_id  = pick_idx;
                end else if (instr_end_in && stop_cmd_in) begin
                    next_st = irq_ctrl_pkg::ST_STOP;
                end else if (instr_end_in && halt_cmd_in) begin
                    next_st = irq_ctrl_pkg::ST_HALT;
                end
            end
            irq_ctrl_pkg::ST_HALT: begin
                if (grant_now) begin
                    next_st  = irq_ctrl_pkg::ST_SEQ;
                    next_cyc = 6'h01;
                    next_id  = pick_idx;
                end
            end
            irq_ctrl_pkg::ST_SEQ: begin
                if (cyc == irq_ctrl_pkg::ISR_FETCH_CYCLE) begin
                    next_st  = irq_ctrl_pkg::ST_RUN;
                    next_cyc = irq_ctrl_pkg::CYC_RESET;
                end else begin
                    next_cyc = 6'(cyc + 6'h01);
                end
                // vector bytes come back one cycle after each read strobe
                if (cyc == 6'(irq_ctrl_pkg::VEC_HI_CYCLE + 6'h01)) begin
                    next_vec_hi = vec_data_in;
                end
                if (cyc == 6'(irq_ctrl_pkg::VEC_LO_CYCLE + 6'h01)) begin
                    next_vec_lo = vec_data_in;
                end
            end
            irq_ctrl_pkg::ST_STOP: begin
                next_st = irq_ctrl_pkg::ST_STOP;
            end
        endcase
        in_seq = (next_st == irq_ctrl_pkg::ST_SEQ);
        // stacking phase: PC low, PC high, then flags
        if (in_seq && (next_cyc == irq_ctrl_pkg::PUSH_PCL_CYCLE)) begin
            next_push     = 1'b1;
            next_push_sel = irq_ctrl_pkg::PUSH_PCL;
        end
        if (in_seq && (next_cyc == irq_ctrl_pkg::PUSH_PCH_CYCLE)) begin
            next_push     = 1'b1;
            next_push_sel = irq_ctrl_pkg::PUSH_PCH;
        end
        if (in_seq && (next_cyc == irq_ctrl_pkg::PUSH_FLG_CYCLE)) begin
            next_push     = 1'b1;
            next_push_sel = irq_ctrl_pkg::PUSH_FLG;
        end
        // vector fetch phase, high byte first
        if (in_seq && (next_cyc == irq_ctrl_pkg::VEC_HI_CYCLE)) begin
            next_vec_rd   = 1'b1;
            next_vec_addr = vec_slot;
        end
        if (in_seq && (next_cyc == irq_ctrl_pkg::VEC_LO_CYCLE)) begin
            next_vec_rd   = 1'b1;
            next_vec_addr = vec_slot | 16'h0001;
        end
        if (in_seq && (next_cyc == irq_ctrl_pkg::ISR_FETCH_CYCLE)) begin
            next_isr = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st               <= irq_ctrl_pkg::ST_RUN;
            cyc              <= irq_ctrl_pkg::CYC_RESET;
            cur_id           <= 3'h0;
            vec_hi           <= 8'h00;
            vec_lo           <= 8'h00;
            int_grant_out    <= 1'b0;
            grant_id_out     <= 3'h0;
            cpu_hold_out     <= 1'b0;
            push_strobe_out  <= 1'b0;
            push_sel_out     <= irq_ctrl_pkg::PUSH_PCL;
            vec_rd_out       <= 1'b0;
            vec_addr_out     <= irq_ctrl_pkg::ADDR_RESET;
            isr_fetch_out    <= 1'b0;
            isr_addr_out     <= irq_ctrl_pkg::ADDR_RESET;
            cpu_clk_en_out   <= 1'b1;
            osc_en_out       <= 1'b1;
            timer_run_out    <= 1'b1;
            restart_addr_out <= irq_ctrl_pkg::RESTART_ADDR;
        end else if (ce_in) begin
            st              <= next_st;
            cyc             <= next_cyc;
            cur_id          <= next_id;
            vec_hi          <= next_vec_hi;
            vec_lo          <= next_vec_lo;
            int_grant_out   <= grant_now;
            grant_id_out    <= grant_now ? pick_idx : grant_id_out;
            cpu_hold_out    <= in_seq;
            push_strobe_out <= next_push;
            push_sel_out    <= next_push_sel;
            vec_rd_out      <= next_vec_rd;
            vec_addr_out    <= next_vec_addr;
            isr_fetch_out   <= next_isr;
            isr_addr_out    <= next_isr ? {next_vec_hi, next_vec_lo} : isr_addr_out;
            // halt keeps oscillator and timers, stop kills both
            cpu_clk_en_out  <= (next_st == irq_ctrl_pkg::ST_RUN);
            osc_en_out      <= (next_st != irq_ctrl_pkg::ST_STOP);
            timer_run_out   <= (next_st != irq_ctrl_pkg::ST_STOP);
        end
    end

    // checks assume ce_in stays high during an entry sequence
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_grant_gate;
        grant_now |-> mask[irq_ctrl_pkg::GLOBAL_EN_BIT] && mask[pick_idx] && pend[pick_idx];
    endproperty
    a_grant_gate: assert property (p_grant_gate) else $error("grant without enable");

    property p_grant_disables;
        grant_now && ce_in |=> !mask[irq_ctrl_pkg::GLOBAL_EN_BIT] && int_grant_out;
    endproperty
    a_grant_disables: assert property (p_grant_disables) else $error("global enable kept");

    property p_sample_point;
        int_grant_out |-> $past(instr_end_in) || ($past(st) == irq_ctrl_pkg::ST_HALT);
    endproperty
    a_sample_point: assert property (p_sample_point) else $error("grant mid instruction");

    property p_pend_clear;
        grant_now && ce_in && !hw_set[pick_idx] |=> !pend[$past(pick_idx)];
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");

    property p_sw_raise;
        wr_pend && ce_in && !grant_now && st != irq_ctrl_pkg::ST_STOP
            |=> (pend & $past(reg_wdata_in[5:0])) == $past(reg_wdata_in[5:0]);
    endproperty
    a_sw_raise: assert property (p_sw_raise) else $error("software set lost");

    property p_stack;
        grant_now && ce_in |-> ##48 (push_strobe_out && push_sel_out == irq_ctrl_pkg::PUSH_FLG);
    endproperty
    a_stack: assert property (p_stack) else $error("flags push late");

    property p_vec;
        grant_now && ce_in |-> ##50 vec_rd_out ##4 (vec_rd_out && vec_addr_out[0]);
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch wrong");

    property p_isr;
        grant_now && ce_in |-> ##1 cpu_hold_out [*8] ##50 isr_fetch_out;
    endproperty
    a_isr: assert property (p_isr) else $error("routine fetch not at 58");

    property p_halt_hold;
        st == irq_ctrl_pkg::ST_HALT && !grant_now && ce_in |=> st == irq_ctrl_pkg::ST_HALT && osc_en_out;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left early");

    property p_stop;
        st == irq_ctrl_pkg::ST_STOP |=> st == irq_ctrl_pkg::ST_STOP && !osc_en_out && !cpu_clk_en_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left without reset");

    c_grant_run: cover property (st == irq_ctrl_pkg::ST_RUN && grant_now);
    c_grant_halt: cover property (st == irq_ctrl_pkg::ST_HALT && grant_now);
    c_stop: cover property (st == irq_ctrl_pkg::ST_STOP);
    c_isr: cover property (isr_fetch_out);

endmodule // vectored_interrupt_and_sleep_control

// ---- test/prog_mem_model.sv ----
// program memory model answering the controller's vector byte reads
`timescale 1ns/10ps
module prog_mem_model (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        vec_rd_in,
    input  wire logic [15:0] vec_addr_in,
    output logic [7:0]       vec_data_out
);
    // byte valid one cycle only; inverted on every later cycle so data read one cycle late does not match
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vec_data_out <= 8'h5A;
        end else if (vec_rd_in) begin
            vec_data_out <= 8'hC0 ^ vec_addr_in[7:0];
        end else begin
            vec_data_out <= ~vec_data_out;
        end
    end
endmodule // prog_mem_model

// ---- test/vectored_interrupt_and_sleep_control_tb.sv ----
// self-checking bench for the interrupt and sleep controller
`timescale 1ns/10ps
module vectored_interrupt_and_sleep_control_tb;
    localparam logic [7:0] PRIO = irq_ctrl_pkg::PRIO_ADDR;
    localparam logic [7:0] PEND = irq_ctrl_pkg::PEND_ADDR;
    localparam logic [7:0] MASK = irq_ctrl_pkg::MASK_ADDR;
    logic        mclk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, instr_end_in = 1'b0;
    logic        halt_cmd_in = 1'b0, stop_cmd_in = 1'b0, ser_tx_req_in = 1'b0, ser_rx_req_in = 1'b0;
    logic        tmr0_req_in = 1'b0, tmr1_req_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [3:0]  port3_request_lines_in = 4'h0;
    logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, vec_data_in, reg_rdata_out;
    logic        int_grant_out, cpu_hold_out, push_strobe_out, vec_rd_out, isr_fetch_out;
    logic        cpu_clk_en_out, osc_en_out, timer_run_out;
    logic [2:0]  grant_id_out;
    logic [1:0]  push_sel_out;
    logic [15:0] vec_addr_out, isr_addr_out, restart_addr_out;
    int          n_errors = 0, samples_checked = 0, cycles = 0;

    vectored_interrupt_and_sleep_control i_dut (
        .mclk_in, .rst_n_in, .ce_in, .instr_end_in, .halt_cmd_in, .stop_cmd_in, .port3_request_lines_in,
        .ser_tx_req_in, .ser_rx_req_in, .tmr0_req_in, .tmr1_req_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
        .reg_wdata_in, .vec_data_in, .reg_rdata_out, .int_grant_out, .grant_id_out, .cpu_hold_out,
        .push_strobe_out, .push_sel_out, .vec_rd_out, .vec_addr_out, .isr_fetch_out, .isr_addr_out,
        .cpu_clk_en_out, .osc_en_out, .timer_run_out, .restart_addr_out
    );
    prog_mem_model i_mem (.mclk_in, .rst_n_in, .vec_rd_in(vec_rd_out), .vec_addr_in(vec_addr_out),
                          .vec_data_out(vec_data_in));

    always #2 mclk_in = ~mclk_in;
    // hang guard: whole run needs well under this many cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge mclk_in);
        reg_rd_in = 1'b0;
        chk(reg_rdata_out === e, "register read");
    endtask
    // one instruction end, optionally carrying a sleep command (no-op assumed just before)
    task automatic iend(input logic h, input logic s);
        @(negedge mclk_in);
        instr_end_in = 1'b1;
        halt_cmd_in = h;
        stop_cmd_in = s;
        @(negedge mclk_in);
        instr_end_in = 1'b0;
        halt_cmd_in = 1'b0;
        stop_cmd_in = 1'b0;
    endtask
    // waits for the grant pulse, then checks the whole entry sequence cycle by cycle
    task automatic entry(input logic [2:0] id);
        int c;
        logic [15:0] va;
        c = 0;
        while (int_grant_out !== 1'b1 && c < 20) begin
            @(negedge mclk_in);
            c++;
        end
        chk(grant_id_out === id, "granted index");
        for (c = 1; c <= 60; c++) begin
            va = 16'(2 * id) + 16'(c == 54);
            chk(int_grant_out === (c == 1) && cpu_hold_out === (c <= 58) && cpu_clk_en_out === (c >= 59)
                && push_strobe_out === (c == 16 || c == 32 || c == 48) && isr_fetch_out === (c == 58)
                && vec_rd_out === (c == 50 || c == 54), "entry timing");
            if (c == 16 || c == 32 || c == 48) chk(push_sel_out === 2'(c / 16 - 1), "push order");
            if (c == 50 || c == 54) chk(vec_addr_out === va, "vector address");
            if (c == 58) chk(isr_addr_out === {8'hC0 ^ 8'(2 * id), 8'hC0 ^ 8'(2 * id + 1)}, "routine");
            @(negedge mclk_in);
        end
    endtask

    task automatic t_regs();
        rd(PEND, 8'h00);
        rd(MASK, 8'h00);
        rd(8'hF8, 8'h00);
        wr(MASK, 8'h7F);
        rd(MASK, 8'h7F);
        wr(PRIO, 8'h0D);
        rd(PRIO, 8'h00);
        wr(PEND, 8'hFF);
        rd(PEND, 8'h3F);
        // a write while the clock enable is low must leave the mask untouched
        ce_in = 1'b0;
        wr(MASK, 8'hFF);
        ce_in = 1'b1;
        rd(MASK, 8'h7F);
        wr(PEND, 8'h00);
        wr(MASK, 8'h00);
        $display("registers done");
    endtask
    // each source alone, global enable off: pending latches, nothing granted
    task automatic t_sources();
        logic [2:0] ids [8] = '{3'h3, 3'h2, 3'h0, 3'h1, 3'h3, 3'h4, 3'h4, 3'h5};
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk_in);
            {tmr1_req_in, tmr0_req_in, ser_tx_req_in, ser_rx_req_in, port3_request_lines_in} = 8'h01 << i;
            repeat (6) @(negedge mclk_in);
            {tmr1_req_in, tmr0_req_in, ser_tx_req_in, ser_rx_req_in, port3_request_lines_in} = 8'h00;
            iend(1'b0, 1'b0);
            chk(int_grant_out === 1'b0, "masked grant");
            rd(PEND, 8'h01 << ids[i]);
            wr(PEND, 8'h00);
        end
        $display("sources done");
    endtask
    task automatic t_prio();
        wr(PRIO, 8'h05);
        wr(PEND, 8'h21);
        wr(MASK, 8'hA1);
        repeat (4) begin
            @(negedge mclk_in);
            chk(int_grant_out === 1'b0, "grant before instruction end");
        end
        iend(1'b0, 1'b0);
        entry(3'h5);
        rd(PEND, 8'h01);
        rd(MASK, 8'h21);
        iend(1'b0, 1'b0);
        chk(int_grant_out === 1'b0, "grant with global enable off");
        wr(PRIO, 8'h00);
        wr(MASK, 8'hA1);
        iend(1'b0, 1'b0);
        entry(3'h0);
        wr(PRIO, 8'h03);
        wr(PEND, 8'h30);
        wr(MASK, 8'hB0);
        iend(1'b0, 1'b0);
        entry(3'h4);
        rd(PEND, 8'h20);
        wr(PRIO, 8'h08);
        // two pending so the falling direction must prefer 5 over 4
        wr(PEND, 8'h30);
        wr(MASK, 8'hB0);
        iend(1'b0, 1'b0);
        entry(3'h5);
        $display("priority done");
    endtask
    task automatic t_halt();
        wr(MASK, 8'hA0);
        iend(1'b1, 1'b0);
        tmr0_req_in = 1'b1;
        repeat (8) begin
            @(negedge mclk_in);
            chk(cpu_clk_en_out === 1'b0 && osc_en_out === 1'b1 && timer_run_out === 1'b1
                && int_grant_out === 1'b0, "halt state");
        end
        tmr1_req_in = 1'b1;
        entry(3'h5);
        tmr1_req_in = 1'b0;
        tmr0_req_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        chk(cpu_clk_en_out === 1'b1, "resume after halt");
        rd(PEND, 8'h10);
        wr(PEND, 8'h00);
        $display("halt done");
    endtask
    task automatic t_stop();
        wr(MASK, 8'hA0);
        iend(1'b0, 1'b1);
        tmr1_req_in = 1'b1;
        wr(PEND, 8'h20);
        repeat (10) begin
            @(negedge mclk_in);
            chk(cpu_clk_en_out === 1'b0 && osc_en_out === 1'b0 && timer_run_out === 1'b0
                && int_grant_out === 1'b0, "stop state");
        end
        tmr1_req_in = 1'b0;
        rst_n_in = 1'b0;
        @(negedge mclk_in);
        chk(restart_addr_out === 16'h000C && osc_en_out === 1'b1 && cpu_clk_en_out === 1'b1, "restart");
        rst_n_in = 1'b1;
        rd(PEND, 8'h00);
        rd(MASK, 8'h00);
        $display("stop done");
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge mclk_in);
        rst_n_in = 1'b1;
        t_regs();
        t_sources();
        t_prio();
        t_halt();
        t_stop();
        give_verdict();
    end
endmodule // vectored_interrupt_and_sleep_control_tb
